//--- pkg/dia_regs.vh
/*
  Constants for the digital input action decoder: register offsets,
  action codes, field positions, reset values and the filter timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DIA_REGS_VH
`define DIA_REGS_VH

// register offsets (byte addresses, one 32-bit word each)
`define DIA_OFS_ASG_LO    8'h00
`define DIA_OFS_ASG_HI    8'h04
`define DIA_OFS_CTRL      8'h08
`define DIA_OFS_MON       8'h0C
`define DIA_OFS_STAT      8'h10

// action codes of one 4-bit assignment field
`define DIA_ACT_NONE      4'h0
`define DIA_ACT_RST       4'h1
`define DIA_ACT_HOLD      4'h2
`define DIA_ACT_ADV       4'h3
`define DIA_ACT_FIX       4'h4
`define DIA_ACT_MAN       4'h5
`define DIA_ACT_LOGIC     4'h6
`define DIA_ACT_PAT2      4'h7
`define DIA_ACT_PAT3      4'h8
`define DIA_ACT_PAT4      4'h9
`define DIA_ACT_PAT5      4'hA

// control register fields
`define DIA_CTRL_EXT_BIT  0
`define DIA_CTRL_GATE_LSB 2

// logic source gate modes
`define DIA_GATE_DIRECT   2'h0
`define DIA_GATE_INVERT   2'h1
`define DIA_GATE_TOGGLE   2'h2

// reset values
`define DIA_RST_ASG       40'h0
`define DIA_RST_CTRL      32'h0
`define DIA_RST_PATTERN   5'h01

// pattern limits
`define DIA_PAT_MAX       5'h14
`define DIA_PAT_BASE5     4
`define DIA_PAT_BASE8     7

// input filter: minimum stable time in ms and clock rate in kHz
`define DIA_FILT_MS       100
`define DIA_CLK_KHZ       50000
`define DIA_FILT_CYC      (`DIA_FILT_MS * `DIA_CLK_KHZ)

`endif

//--- design/dia_decoder.v
/*
  Digital input action decoder: synchronises and filters ten contact
  inputs, maps inputs 2 to 10 onto assigned actions, applies blocking,
  priority and claim handling and decodes the external start pattern.
  Assumes contact inputs high while shorted, a register master that
  keeps to the one-cycle strobe protocol, and a core that reads the
  action outputs as levels.
*/
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dia_regs.vh"

module dia_decoder #(
  parameter integer FILT_CYC = `DIA_FILT_CYC
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // contact inputs, bit 0 is input 1
  input  wire [9:0]  din_i,
  // state of the core
  input  wire        autotune_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        we_i,
  input  wire        re_i,
  output reg  [31:0] rdata_o,
  // actions to the sequencing core
  output reg         run_o,
  output reg         force_reset_o,
  output reg         hold_suspend_o,
  output reg         step_advance_o,
  output reg         fix_mode_o,
  output reg         manual_output_o,
  output reg  [9:0]  logic_o,
  output reg  [4:0]  start_pattern_o,
  output reg         pattern_ext_o,
  // front panel locks and monitor
  output reg  [6:0]  panel_lock_o,
  output reg  [9:0]  monitor_o
);

  localparam [22:0] FILT_END = (FILT_CYC > 1) ? FILT_CYC[22:0] - 23'h1 : 23'h0;

  reg  [9:0]  sync1;
  reg  [9:0]  sync2;
  reg  [9:0]  filt;
  reg  [9:0]  filt_d;
  reg  [39:0] asg;
  reg  [39:0] next_asg;
  reg  [31:0] ctrl;
  reg  [39:0] cand;
  reg  [3:0]  fld;
  reg  [3:0]  w5;
  reg  [3:0]  w8;
  reg  [4:0]  ptn_raw;
  reg  [4:0]  ptn_dec;
  reg  [3:0]  ptn_w;
  reg  [9:0]  shifted;
  reg         has_rst;
  reg         has_hold;
  reg         has_adv;
  reg         has_fix;
  reg         has_man;
  reg         has_logic;
  reg         has_pat;
  reg         sel_rst;
  reg         sel_hold;
  reg         sel_adv_rise;
  reg         sel_fix;
  reg         sel_man;
  reg  [31:0] rd_mux;
  wire [9:0]  rise;
  wire [9:0]  next_logic;
  integer     k;

  assign rise = filt & ~filt_d;

  // per-input synchroniser and stability filter, and the logic gate of inputs 2 to 10
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_in
      reg [22:0] cnt;
      reg        tog;
      always @(posedge clk_i) begin
        if (!nrst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          filt[g]  <= 1'b0;
          filt_d[g] <= 1'b0;
          cnt      <= 23'h0;
        end else begin
          sync1[g] <= din_i[g];
          sync2[g] <= sync1[g];
          filt_d[g] <= filt[g];
          if (sync2[g] == filt[g]) begin
            cnt <= 23'h0;
          end else if (cnt == FILT_END) begin
            filt[g] <= sync2[g];
            cnt     <= 23'h0;
          end else begin
            cnt <= cnt + 23'h1;
          end
        end
      end
      // toggled source state flips on each filtered rising edge
      always @(posedge clk_i) begin
        if (!nrst_i) begin
          tog <= 1'b0;
        end else if (rise[g]) begin
          tog <= ~tog;
        end
      end
      if (g == 0) begin : g_run
        assign next_logic[g] = 1'b0;
      end else begin : g_lg
        wire [1:0] gm = ctrl[`DIA_CTRL_GATE_LSB + 2*g +: 2];
        wire       on = (gm == `DIA_GATE_INVERT) ? ~filt[g] :
                        (gm == `DIA_GATE_TOGGLE) ? tog : filt[g];
        // a removed logic assignment stops at once
        assign next_logic[g] = (asg[4*g +: 4] == `DIA_ACT_LOGIC) & on;
      end
    end
  endgenerate

  // assignment write: placement checks, then pattern claims
  always @* begin
    cand = asg;
    next_asg = asg;
    fld = `DIA_ACT_NONE;
    w5 = 4'h0;
    w8 = 4'h0;
    if (we_i && addr_i == `DIA_OFS_ASG_LO) begin
      cand[35:4] = wdata_i;
    end
    if (we_i && addr_i == `DIA_OFS_ASG_HI) begin
      cand[39:36] = wdata_i[3:0];
    end
    cand[3:0] = `DIA_ACT_NONE;
    for (k = 1; k < 10; k = k + 1) begin
      fld = cand[4*k +: 4];
      if (fld > `DIA_ACT_PAT5) begin
        fld = asg[4*k +: 4];
      end
      if (fld >= `DIA_ACT_PAT2 && !(k == 4 ||
          (k == 7 && fld <= `DIA_ACT_PAT3))) begin
        fld = asg[4*k +: 4];
      end
      next_asg[4*k +: 4] = fld;
    end
    if (next_asg[19:16] >= `DIA_ACT_PAT2) begin
      w5 = next_asg[19:16] - `DIA_ACT_PAT2 + 4'h2;
    end
    for (k = 5; k < 10; k = k + 1) begin
      if (k <= 3 + w5) begin
        next_asg[4*k +: 4] = `DIA_ACT_NONE;
      end
    end
    if (next_asg[31:28] >= `DIA_ACT_PAT2) begin
      w8 = next_asg[31:28] - `DIA_ACT_PAT2 + 4'h2;
    end
    for (k = 8; k < 10; k = k + 1) begin
      if (k <= 6 + w8) begin
        next_asg[4*k +: 4] = `DIA_ACT_NONE;
      end
    end
  end

  // action resolution: scanned downward so the lowest input wins
  always @* begin
    has_rst = 1'b0;
    has_hold = 1'b0;
    has_adv = 1'b0;
    has_fix = 1'b0;
    has_man = 1'b0;
    has_logic = 1'b0;
    sel_rst = 1'b0;
    sel_hold = 1'b0;
    sel_adv_rise = 1'b0;
    sel_fix = 1'b0;
    sel_man = 1'b0;
    for (k = 9; k > 0; k = k - 1) begin
      case (asg[4*k +: 4])
        `DIA_ACT_RST: begin
          has_rst = 1'b1;
          sel_rst = filt[k];
        end
        `DIA_ACT_HOLD: begin
          has_hold = 1'b1;
          sel_hold = filt[k];
        end
        `DIA_ACT_ADV: begin
          has_adv = 1'b1;
          sel_adv_rise = rise[k];
        end
        `DIA_ACT_FIX: begin
          has_fix = 1'b1;
          sel_fix = filt[k];
        end
        `DIA_ACT_MAN: begin
          has_man = 1'b1;
          sel_man = filt[k];
        end
        `DIA_ACT_LOGIC: begin
          has_logic = 1'b1;
        end
        default: begin
          has_logic = has_logic;
        end
      endcase
    end
  end

  // pattern decode: input 5 group outranks input 8 group
  always @* begin
    ptn_w = 4'h0;
    shifted = 10'h000;
    has_pat = 1'b0;
    if (asg[19:16] >= `DIA_ACT_PAT2) begin
      has_pat = 1'b1;
      ptn_w = asg[19:16] - `DIA_ACT_PAT2 + 4'h2;
      shifted = filt >> `DIA_PAT_BASE5;
    end else if (asg[31:28] >= `DIA_ACT_PAT2) begin
      has_pat = 1'b1;
      ptn_w = asg[31:28] - `DIA_ACT_PAT2 + 4'h2;
      shifted = filt >> `DIA_PAT_BASE8;
    end
    ptn_raw = shifted[4:0] & ~(5'h1F << ptn_w);
    if (ptn_raw == 5'h00) begin
      ptn_dec = 5'h01;
    end else if (ptn_raw > `DIA_PAT_MAX) begin
      ptn_dec = `DIA_PAT_MAX;
    end else begin
      ptn_dec = ptn_raw;
    end
  end

  // configuration registers
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      asg  <= `DIA_RST_ASG;
      ctrl <= `DIA_RST_CTRL;
    end else begin
      asg <= next_asg;
      if (we_i && addr_i == `DIA_OFS_CTRL) begin
        ctrl <= wdata_i;
      end
    end
  end

  // action state; unassigned level actions keep their last value, except logic outputs and pattern_ext_o, which clear
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      run_o           <= 1'b0;
      force_reset_o   <= 1'b0;
      hold_suspend_o  <= 1'b0;
      step_advance_o  <= 1'b0;
      fix_mode_o      <= 1'b0;
      manual_output_o <= 1'b0;
      logic_o         <= 10'h000;
      start_pattern_o <= `DIA_RST_PATTERN;
      pattern_ext_o   <= 1'b0;
      panel_lock_o    <= 7'h00;
      monitor_o       <= 10'h000;
    end else begin
      if (has_rst) begin
        force_reset_o <= sel_rst;
      end
      if (force_reset_o) begin
        run_o <= 1'b0;
      end else if (rise[0]) begin
        run_o <= ~run_o;
      end
      if (has_hold) begin
        hold_suspend_o <= sel_hold;
      end
      if (has_adv && sel_adv_rise && !hold_suspend_o) begin
        step_advance_o <= ~step_advance_o;
      end
      if (has_fix) begin
        fix_mode_o <= sel_fix;
      end
      if (has_man && !autotune_i) begin
        manual_output_o <= sel_man;
      end
      logic_o <= next_logic;
      pattern_ext_o <= ctrl[`DIA_CTRL_EXT_BIT] & has_pat;
      if (ctrl[`DIA_CTRL_EXT_BIT] && has_pat && !fix_mode_o) begin
        start_pattern_o <= ptn_dec;
      end
      panel_lock_o <= {has_pat, has_logic, has_man, has_fix,
                       has_adv, has_hold, has_rst};
      monitor_o <= filt;
    end
  end

  // register read, data in the cycle after the strobe
  always @* begin
    case (addr_i)
      `DIA_OFS_ASG_LO: rd_mux = asg[35:4];
      `DIA_OFS_ASG_HI: rd_mux = {28'h0, asg[39:36]};
      `DIA_OFS_CTRL:   rd_mux = {10'h0, ctrl[21:2], 1'b0, ctrl[0]};
      `DIA_OFS_MON:    rd_mux = {22'h0, filt};
      `DIA_OFS_STAT:   rd_mux = {13'h0, panel_lock_o, pattern_ext_o,
                                 start_pattern_o, manual_output_o,
                                 fix_mode_o, step_advance_o,
                                 hold_suspend_o, force_reset_o, run_o};
      default:         rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0;
    end else if (re_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 32'h0;
    end
  end

endmodule // dia_decoder

`default_nettype wire

//--- sim/dia_contacts.sv
/*
  Contact model: ten switches or open-collector drivers.
  Assumes the bench asks for levels on want_i.
*/
`timescale 1ns/100ps
`default_nettype none
module dia_contacts #(
  parameter int HOLD = 8
) (
  // clock and requested levels
  input  wire logic       clk_i,
  input  wire logic [9:0] want_i,
  // contact levels
  output var  logic [9:0] din_o
);
  int cnt = 0;
  initial din_o = 10'h000;
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (want_i != din_o && cnt >= HOLD) begin
      din_o <= want_i;
      cnt   <= 0;
    end
  end
endmodule // dia_contacts
`default_nettype wire

//--- sim/dia_decoder_assertions.sv
/*
  Port checker for the input action decoder.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module dia_decoder_assertions (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [9:0]  din_i,
  input wire logic        autotune_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        we_i,
  input wire logic        re_i,
  input wire logic [31:0] rdata_o,
  input wire logic        run_o,
  input wire logic        force_reset_o,
  input wire logic        hold_suspend_o,
  input wire logic        step_advance_o,
  input wire logic        fix_mode_o,
  input wire logic        manual_output_o,
  input wire logic [9:0]  logic_o,
  input wire logic [4:0]  start_pattern_o,
  input wire logic        pattern_ext_o,
  input wire logic [6:0]  panel_lock_o,
  input wire logic [9:0]  monitor_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence mon_read;
    re_i && addr_i == 8'h0C;
  endsequence
  sequence mon_move;
    $changed(monitor_o);
  endsequence
  mon_read_a: assert property (
    mon_read |=> rdata_o == {22'h0, monitor_o}) else $error("monitor read");
  filt_level_a: assert property (
    mon_move |-> ((monitor_o ^ $past(monitor_o)) & (monitor_o ^ $past(din_i, 4))) == 10'h000)
    else $error("filter level");
  hold_adv_a: assert property (
    hold_suspend_o |=> $stable(step_advance_o)) else $error("advance in hold");
  tune_man_a: assert property (
    autotune_i |=> $stable(manual_output_o)) else $error("manual in autotune");
  force_run_a: assert property (
    force_reset_o |=> !run_o) else $error("run in forced reset");
  fix_pat_a: assert property (
    fix_mode_o |=> $stable(start_pattern_o)) else $error("pattern in fixed mode");
  ext_pat_a: assert property (
    !pattern_ext_o |-> $stable(start_pattern_o)) else $error("pattern without ext");
  pat_range_a: assert property (
    start_pattern_o != 5'h00 && start_pattern_o <= 5'h14) else $error("pattern range");
  in1_logic_a: assert property (
    logic_o[0] == 1'b0) else $error("input 1 logic");
endmodule // dia_decoder_assertions
bind dia_decoder dia_decoder_assertions chk_i (.clk_i, .nrst_i, .din_i, .autotune_i,
  .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .run_o, .force_reset_o, .hold_suspend_o,
  .step_advance_o, .fix_mode_o, .manual_output_o, .logic_o, .start_pattern_o,
  .pattern_ext_o, .panel_lock_o, .monitor_o);
`default_nettype wire

//--- sim/dia_decoder_test.sv
/*
  Self-checking bench for the input action decoder.
  Assumes the contact model and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module dia_decoder_test;
  logic        clk_i, nrst_i, autotune_i, we_i, re_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [9:0]  want, din_i, logic_o, monitor_o;
  logic [4:0]  start_pattern_o;
  logic [6:0]  panel_lock_o;
  logic        run_o, force_reset_o, hold_suspend_o, step_advance_o;
  logic        fix_mode_o, manual_output_o, pattern_ext_o;
  int          fail_count = 0;
  int          total_checks = 0;
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  dia_contacts #(.HOLD(8)) far (.clk_i(clk_i), .want_i(want), .din_o(din_i));
  dia_decoder #(.FILT_CYC(4)) uut (.clk_i, .nrst_i, .din_i, .autotune_i, .addr_i,
    .wdata_i, .we_i, .re_i, .rdata_o, .run_o, .force_reset_o, .hold_suspend_o,
    .step_advance_o, .fix_mode_o, .manual_output_o, .logic_o, .start_pattern_o,
    .pattern_ext_o, .panel_lock_o, .monitor_o);
  task results;
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // contacts change, then the filter and the outputs settle
  task step(input logic [9:0] w);
    @(posedge clk_i);
    want <= w;
    repeat (24) @(posedge clk_i);
    #1;
  endtask
  initial begin
    nrst_i = 1'b0;
    autotune_i = 1'b0;
    we_i = 1'b0;
    re_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    want = 10'h000;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(8'h10, 32'h40);
    rd(8'h14, 32'h0);
    wr(8'h00, 32'h14668532);
    rd(8'h00, 32'h14008532);
    wr(8'h00, 32'h14008539);
    rd(8'h00, 32'h14008532);
    wr(8'h04, 32'h6);
    wr(8'h08, 32'h00100001);
    step(10'h000);
    chk(32'(panel_lock_o), 32'h7F);
    chk(32'(pattern_ext_o), 32'h1);
    chk(32'(logic_o), 32'h200);
    step(10'h001);
    chk(32'(run_o), 32'h1);
    step(10'h000);
    chk(32'(run_o), 32'h1);
    step(10'h200);
    chk(32'(logic_o), 32'h0);
    step(10'h050);
    chk(32'(start_pattern_o), 32'h5);
    chk(32'(monitor_o), 32'h50);
    rd(8'h0C, 32'h50);
    step(10'h000);
    chk(32'(start_pattern_o), 32'h1);
    step(10'h002);
    chk(32'(hold_suspend_o), 32'h1);
    step(10'h006);
    chk(32'(step_advance_o), 32'h0);
    step(10'h002);
    step(10'h000);
    chk(32'(hold_suspend_o), 32'h0);
    step(10'h004);
    chk(32'(step_advance_o), 32'h1);
    @(posedge clk_i);
    autotune_i <= 1'b1;
    step(10'h008);
    chk(32'(manual_output_o), 32'h0);
    @(posedge clk_i);
    autotune_i <= 1'b0;
    step(10'h008);
    chk(32'(manual_output_o), 32'h1);
    step(10'h080);
    chk(32'(fix_mode_o), 32'h1);
    step(10'h0C0);
    chk(32'(start_pattern_o), 32'h1);
    step(10'h100);
    chk(32'({force_reset_o, run_o}), 32'h2);
    step(10'h101);
    chk(32'(run_o), 32'h0);
    step(10'h000);
    chk(32'(force_reset_o), 32'h0);
    // input 10 switched to the toggled gate; its state is set from the earlier press
    wr(8'h08, 32'h00200001);
    step(10'h200);
    chk(32'(logic_o), 32'h0);
    step(10'h000);
    chk(32'(logic_o), 32'h0);
    step(10'h200);
    chk(32'(logic_o), 32'h200);
    wr(8'h04, 32'h0);
    step(10'h200);
    chk(32'(logic_o), 32'h0);
    chk(32'(panel_lock_o), 32'h5F);
    results();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    results();
  end
endmodule // dia_decoder_test
`default_nettype wire
